// ### logic/mit_pkg.sv
// Purpose: Shared types and constants for the instruction timing core
// Assumes: 8-bit accumulator machine, one system clock
// Notes:   Opcode values are the standard binary encodings
package mit_pkg;
    localparam int LEN_W = 2;
    localparam int CYC_W = 4;
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [15:0] DATA_POINTER16_RST = 16'h0000;
    localparam int SPACE_BIT = 7;
    localparam logic [7:0] OP_NOP      = 8'h00;
    localparam logic [7:0] OP_SPARE    = 8'ha5;
    localparam logic [7:0] OP_RLC      = 8'h33;
    localparam logic [7:0] OP_RRC      = 8'h13;
    localparam logic [7:0] OP_ADD_DIR  = 8'h25;
    localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IND = 8'h96;
    localparam logic [7:0] OP_ANL_DIMM = 8'h53;
    localparam logic [7:0] OP_LD_DATA_POINTER16  = 8'h90;
    localparam logic [7:0] OP_XW_DATA_POINTER16  = 8'hf0;
    localparam logic [7:0] OP_MUL      = 8'ha4;
    localparam logic [7:0] OP_JC       = 8'h40;

    typedef enum logic [3:0] {
        CLS_NOP, CLS_ALU, CLS_XRD, CLS_XWR, CLS_CODE_DP, CLS_CODE_PC,
        CLS_DP_LD, CLS_DP_INC, CLS_BRANCH, CLS_OTHER
    } mit_cls_t;
    typedef enum logic [4:0] {
        AL_NONE, AL_CLR, AL_CPL, AL_RL, AL_RLC, AL_RR, AL_RRC, AL_SWAP,
        AL_INC, AL_DEC, AL_ADD, AL_ADD_WITH_CARRY, AL_SUBTRACT_WITH_BORROW, AL_AND, AL_OR, AL_XOR,
        AL_MOV
    } mit_alu_op_t;
    typedef enum logic [2:0] {AM_NONE, AM_REG, AM_DIR, AM_IND, AM_IMM}
        mit_mode_t;
    typedef enum logic [1:0] {MS_NONE, MS_RAM_LO, MS_RAM_HI, MS_SFR}
        mit_space_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
    } mit_instr_t;

    typedef struct packed {
        logic [LEN_W-1:0] len;
        logic [CYC_W-1:0] cyc;
        mit_cls_t         cls;
        mit_mode_t        mode;
        mit_alu_op_t      alu;
        logic             acc_dst;
    } mit_dec_t;
endpackage

// ### logic/mit_decode.sv
// Purpose: Opcode to length, cycle count, class and source mode
// Assumes: Purely combinational, fed by the sequencer
// Notes:   Conditional branch rows give the not-taken count
`timescale 1ns/1ps
module mit_decode import mit_pkg::*; (
    input  wire logic [7:0] opcode,
    output mit_dec_t        dec
);
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    function automatic mit_dec_t row(input mit_dec_t d, input int l,
                                     input int c, input mit_cls_t k);
        mit_dec_t r;
        r     = d;
        r.len = LEN_W'(l);
        r.cyc = CYC_W'(c);
        r.cls = k;
        return r;
    endfunction

    // Source mode follows the low nibble in every operand-bearing row
    always_comb begin
        dec      = '0;
        dec.cls  = CLS_OTHER;
        dec.alu  = AL_NONE;
        dec.mode = (lo == 4'h4) ? AM_IMM : (lo == 4'h5) ? AM_DIR :
                   (lo[3:1] == 3'b011) ? AM_IND :
                   lo[3] ? AM_REG : AM_NONE;
        dec.len  = LEN_W'(1);
        dec.cyc  = CYC_W'(1);
        if (lo >= 4'h4 && (hi == 4'h2 || hi == 4'h3 || hi == 4'h9 ||
                           hi == 4'h4 || hi == 4'h5 || hi == 4'h6)) begin
            dec.acc_dst = 1'b1;
            case (hi)
                4'h2:    dec.alu = AL_ADD;
                4'h3:    dec.alu = AL_ADD_WITH_CARRY;
                4'h9:    dec.alu = AL_SUBTRACT_WITH_BORROW;
                4'h5:    dec.alu = AL_AND;
                4'h4:    dec.alu = AL_OR;
                default: dec.alu = AL_XOR;
            endcase
            case (dec.mode)
                AM_REG:  dec = row(dec, 1, 1, CLS_ALU);
                AM_IND:  dec = row(dec, 1, 2, CLS_ALU);
                default: dec = row(dec, 2, 2, CLS_ALU);
            endcase
        end else begin
            casez (opcode)
                8'h00, 8'ha5: begin
                    dec      = row(dec, 1, 1, CLS_NOP);
                    dec.mode = AM_NONE;
                end
                8'h42, 8'h52, 8'h62: dec = row(dec, 2, 2, CLS_OTHER);
                8'h43, 8'h53, 8'h63: dec = row(dec, 3, 3, CLS_OTHER);
                8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
                8'h04, 8'h14, 8'hd4: begin
                    dec         = row(dec, 1, 1, CLS_ALU);
                    dec.mode    = AM_NONE;
                    dec.acc_dst = (opcode != 8'hd4);
                    case (opcode)
                        8'he4:   dec.alu = AL_CLR;
                        8'hf4:   dec.alu = AL_CPL;
                        8'h23:   dec.alu = AL_RL;
                        8'h33:   dec.alu = AL_RLC;
                        8'h03:   dec.alu = AL_RR;
                        8'h13:   dec.alu = AL_RRC;
                        8'hc4:   dec.alu = AL_SWAP;
                        8'h04:   dec.alu = AL_INC;
                        8'h14:   dec.alu = AL_DEC;
                        default: dec.alu = AL_NONE;
                    endcase
                end
                8'b000?_1???, 8'hf8, 8'b1111_1???: dec = row(dec, 1, 1, CLS_OTHER);
                8'h05, 8'h15, 8'hf5, 8'hc0, 8'hd0,
                8'b1010_1???, 8'b0111_1???, 8'b1000_1???,
                8'h86, 8'h87, 8'ha6, 8'ha7, 8'h76, 8'h77:
                    dec = row(dec, 2, 2, CLS_OTHER);
                8'h06, 8'h07, 8'h16, 8'h17, 8'hf6, 8'hf7,
                8'hd6, 8'hd7: dec = row(dec, 1, 2, CLS_OTHER);
                8'h85, 8'h75: dec = row(dec, 3, 3, CLS_OTHER);
                8'ha3: begin
                    dec      = row(dec, 1, 1, CLS_DP_INC);
                    dec.mode = AM_NONE;
                end
                8'ha4: begin
                    dec      = row(dec, 1, 4, CLS_OTHER);
                    dec.mode = AM_NONE;
                end
                8'h84: begin
                    dec      = row(dec, 1, 8, CLS_OTHER);
                    dec.mode = AM_NONE;
                end
                8'b1110_1???, 8'hc8, 8'b1100_1???: begin
                    dec         = row(dec, 1, 1, CLS_ALU);
                    dec.alu     = AL_MOV;
                    dec.acc_dst = 1'b1;
                end
                8'he5, 8'h74, 8'hc5: begin
                    dec         = row(dec, 2, 2, CLS_ALU);
                    dec.alu     = AL_MOV;
                    dec.acc_dst = 1'b1;
                end
                8'he6, 8'he7, 8'hc6, 8'hc7: begin
                    dec         = row(dec, 1, 2, CLS_ALU);
                    dec.alu     = AL_MOV;
                    dec.acc_dst = 1'b1;
                end
                8'h90: dec = row(dec, 3, 3, CLS_DP_LD);
                8'h93: dec = row(dec, 1, 3, CLS_CODE_DP);
                8'h83: dec = row(dec, 1, 3, CLS_CODE_PC);
                8'he0, 8'he2, 8'he3: begin
                    dec         = row(dec, 1, 3, CLS_XRD);
                    dec.mode    = AM_NONE;
                    dec.alu     = AL_MOV;
                    dec.acc_dst = 1'b1;
                end
                8'hf0, 8'hf2, 8'hf3: begin
                    dec      = row(dec, 1, 3, CLS_XWR);
                    dec.mode = AM_NONE;
                end
                8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
                    dec = row(dec, 2, 2, CLS_BRANCH);
                8'h10, 8'h20, 8'h30, 8'hb4, 8'hb5, 8'b1011_1???, 8'hd5:
                    dec = row(dec, 3, 3, CLS_BRANCH);
                8'hb6, 8'hb7: dec = row(dec, 3, 4, CLS_BRANCH);
                default: dec.mode = AM_NONE;
            endcase
        end
    end
endmodule // mit_decode

// ### logic/mit_alu.sv
// Purpose: Accumulator arithmetic, logic, rotate and move unit
// Assumes: Combinational; caller decides whether results are kept
// Notes:   Carry passes through unchanged for ops that leave it alone
`timescale 1ns/1ps
module mit_alu import mit_pkg::*; (
    input  wire mit_alu_op_t op,
    input  wire logic [7:0]  acc,
    input  wire logic        carry,
    input  wire logic [7:0]  operand,
    output logic      [7:0]  res,
    output logic             cy_out
);
    logic [8:0] wide;

    // Nine-bit sums give the carry or borrow in the top bit
    always_comb begin
        wide   = 9'h000;
        res    = acc;
        cy_out = carry;
        case (op)
            AL_CLR:  res = 8'h00;
            AL_CPL:  res = ~acc;
            AL_RL:   res = {acc[6:0], acc[7]};
            AL_RR:   res = {acc[0], acc[7:1]};
            AL_RLC:  {cy_out, res} = {acc, carry};
            AL_RRC:  {res, cy_out} = {carry, acc};
            AL_SWAP: res = {acc[3:0], acc[7:4]};
            AL_INC:  res = acc + 8'h01;
            AL_DEC:  res = acc - 8'h01;
            AL_ADD, AL_ADD_WITH_CARRY: begin
                wide = {1'b0, acc} + {1'b0, operand} +
                       {8'h00, (op == AL_ADD_WITH_CARRY) & carry};
                {cy_out, res} = wide;
            end
            AL_SUBTRACT_WITH_BORROW: begin
                wide = {1'b0, acc} - {1'b0, operand} - {8'h00, carry};
                {cy_out, res} = wide;
            end
            AL_AND:  res = acc & operand;
            AL_OR:   res = acc | operand;
            AL_XOR:  res = acc ^ operand;
            AL_MOV:  res = operand;
            default: res = acc;
        endcase
    end
endmodule // mit_alu

// ### logic/mit_core_timing.sv
// Purpose: Instruction sequencer holding each opcode for its cycle count
// Assumes: Fetch unit presents whole instructions; memories answer
//          operand_data by the final cycle of the instruction
// Notes:   Accumulator, carry and data pointer live here
//
// Behaviour
// - external-data-move writes go to on-chip program flash.
// - add and add-with-carry: register 1/1, direct or immediate 2/2, indirect 1/2.
// - subtract-with-borrow times exactly like add.
// - AND/OR/XOR to A: register 1 cycle, others 2; to direct from A 2.
// - AND/OR/XOR immediate into direct byte: 3 bytes, 3 cycles.
// - clear, complement, rotate and nibble swap of A: 1 byte, 1 cycle.
// - rotate through carry both ways; leaving bit to carry, old carry in.
// - A with register 1/1; direct or immediate 2/2; indirect 1/2.
// - direct or immediate to direct 3/3; indirect to direct 2/2.
// - writes to indirect RAM take 2 cycles, 1 or 2 bytes.
// - loading the 16-bit data pointer: 3 bytes, 3 cycles.
// - code byte reads at A plus pointer or PC: 1 byte, 3 cycles.
// - external data moves 1 byte, 3 cycles; 8 or 16 bit address.
// - stack push and pop of a direct byte: 2 bytes, 2 cycles.
// - exchange A with register 1/1, with direct byte 2/2.
// - a conditional branch not taken finishes one cycle sooner.
// - the spare opcode behaves exactly like no-operation.
// - direct above 0x7F selects SFRs; indirect selects upper RAM.
`timescale 1ns/1ps
module mit_core_timing import mit_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire mit_instr_t  instr,
    input  wire logic        instr_valid,
    input  wire logic        branch_taken,
    input  wire logic [7:0]  ri_value,
    input  wire logic [15:0] pc_value,
    input  wire logic [7:0]  operand_data,
    input  wire logic        store_write_en,
    output logic             instr_ready_q,
    output logic             done_q,
    output logic [LEN_W-1:0] len_q,
    output logic [CYC_W-1:0] cycles_q,
    output logic [7:0]       acc_q,
    output logic             carry_q,
    output logic [15:0]      data_pointer16_q,
    output mit_space_t       mem_space_q,
    output logic [7:0]       mem_addr_q,
    output logic             flash_wr_q,
    output logic [15:0]      xaddr_q,
    output logic [7:0]       xwdata_q,
    output logic             code_rd_q,
    output logic [15:0]      code_addr_q
);
    typedef enum logic {ST_IDLE, ST_EXEC} mit_state_t;

    mit_state_t       state_q;
    logic [CYC_W-1:0] cnt_q;
    mit_dec_t         dec;
    mit_dec_t         dec_q;
    mit_instr_t       ins_q;
    mit_dec_t         cur_dec;
    mit_instr_t       cur_ins;
    logic             accept;
    logic             commit;
    logic [CYC_W-1:0] total;
    logic [7:0]       alu_res;
    logic             alu_cy;
    logic [7:0]       alu_opnd;

    mit_decode u_decode (
        .opcode (instr.opcode),
        .dec    (dec)
    );

    // Work on the live decode when the instruction commits on acceptance
    assign cur_dec = (state_q == ST_IDLE) ? dec : dec_q;
    assign cur_ins = (state_q == ST_IDLE) ? instr : ins_q;
    assign alu_opnd = (cur_dec.mode == AM_IMM) ? cur_ins.op1 : operand_data;

    mit_alu u_alu (
        .op      (cur_dec.alu),
        .acc     (acc_q),
        .carry   (carry_q),
        .operand (alu_opnd),
        .res     (alu_res),
        .cy_out  (alu_cy)
    );

    // A taken branch costs one more cycle than the decoded figure
    assign total = dec.cyc + CYC_W'(dec.cls == CLS_BRANCH && branch_taken);
    assign accept = clk_en && instr_valid && instr_ready_q;
    assign commit = (accept && total == CYC_W'(1)) ||
                    (clk_en && state_q == ST_EXEC && cnt_q == CYC_W'(1));

    // Sequencer: ready drops for total-1 cycles, so accepts are
    // spaced by exactly the instruction's cycle count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q       <= ST_IDLE;
            cnt_q         <= '0;
            instr_ready_q <= 1'b1;
            done_q        <= 1'b0;
            len_q         <= '0;
            cycles_q      <= '0;
            dec_q         <= '0;
            ins_q         <= '0;
        end else if (clk_en) begin
            done_q <= commit;
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        len_q    <= dec.len;
                        cycles_q <= total;
                        dec_q    <= dec;
                        ins_q    <= instr;
                        if (total != CYC_W'(1)) begin
                            state_q       <= ST_EXEC;
                            cnt_q         <= total - CYC_W'(1);
                            instr_ready_q <= 1'b0;
                        end
                    end
                end
                ST_EXEC: begin
                    if (cnt_q == CYC_W'(1)) begin
                        state_q       <= ST_IDLE;
                        instr_ready_q <= 1'b1;
                    end
                    cnt_q <= cnt_q - CYC_W'(1);
                end
                default: begin
                    state_q       <= ST_IDLE;
                    instr_ready_q <= 1'b1;
                end
            endcase
        end
    end

    // Accumulator and carry change only at the final cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q   <= ACC_RST;
            carry_q <= 1'b0;
        end else if (clk_en && commit && cur_dec.acc_dst) begin
            acc_q   <= alu_res;
            carry_q <= alu_cy;
        end
    end

    // Data pointer load and increment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_pointer16_q <= DATA_POINTER16_RST;
        end else if (clk_en && commit) begin
            if (cur_dec.cls == CLS_DP_LD) begin
                data_pointer16_q <= {cur_ins.op1, cur_ins.op2};
            end else if (cur_dec.cls == CLS_DP_INC) begin
                data_pointer16_q <= data_pointer16_q + 16'h0001;
            end
        end
    end

    // Address space select: the same byte address means SFR when
    // reached directly and upper RAM when reached through a pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_space_q <= MS_NONE;
            mem_addr_q  <= 8'h00;
        end else if (accept) begin
            case (dec.mode)
                AM_DIR: begin
                    mem_space_q <= instr.op1[SPACE_BIT] ? MS_SFR
                                                        : MS_RAM_LO;
                    mem_addr_q  <= instr.op1;
                end
                AM_IND: begin
                    mem_space_q <= ri_value[SPACE_BIT] ? MS_RAM_HI
                                                       : MS_RAM_LO;
                    mem_addr_q  <= ri_value;
                end
                default: mem_space_q <= MS_NONE;
            endcase
        end
    end

    // External data address: bit 1 of the opcode picks the 8-bit
    // pointer register over the 16-bit data pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xaddr_q <= 16'h0000;
        end else if (accept &&
                     (dec.cls == CLS_XRD || dec.cls == CLS_XWR)) begin
            xaddr_q <= instr.opcode[1] ? {8'h00, ri_value} : data_pointer16_q;
        end
    end

    // Flash write strobe; the store enable gates it so a stray move
    // cannot corrupt program code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flash_wr_q <= 1'b0;
            xwdata_q   <= 8'h00;
        end else if (clk_en) begin
            flash_wr_q <= commit && cur_dec.cls == CLS_XWR &&
                          store_write_en;
            if (commit && cur_dec.cls == CLS_XWR) begin
                xwdata_q <= acc_q;
            end
        end
    end

    // Code byte read, issued the cycle after acceptance
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            code_rd_q   <= 1'b0;
            code_addr_q <= 16'h0000;
        end else if (clk_en) begin
            code_rd_q <= accept && (dec.cls == CLS_CODE_DP ||
                                    dec.cls == CLS_CODE_PC);
            if (accept && dec.cls == CLS_CODE_DP) begin
                code_addr_q <= data_pointer16_q + {8'h00, acc_q};
            end else if (accept && dec.cls == CLS_CODE_PC) begin
                code_addr_q <= pc_value + {8'h00, acc_q};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence busy_then_done2;
        !instr_ready_q ##1 (done_q && instr_ready_q);
    endsequence
    sequence busy_then_done3;
        !instr_ready_q [*2] ##1 (done_q && instr_ready_q);
    endsequence

    add_direct_a: assert property (
        accept && instr.opcode == OP_ADD_DIR |=> busy_then_done2)
        else $error("direct add not 2 cycles");
    subtract_with_borrow_ind_a: assert property (
        accept && instr.opcode == OP_SUBTRACT_WITH_BORROW_IND |=> busy_then_done2)
        else $error("indirect subtract not 2 cycles");
    logic_dimm_a: assert property (
        accept && instr.opcode == OP_ANL_DIMM |=>
        busy_then_done3 ##0 len_q == LEN_W'(3))
        else $error("immediate AND to direct not 3/3");
    rlc_carry_a: assert property (
        accept && instr.opcode == OP_RLC |=>
        done_q && carry_q == $past(acc_q[7]) &&
        acc_q == {$past(acc_q[6:0]), $past(carry_q)})
        else $error("rotate left through carry wrong");
    rrc_carry_a: assert property (
        accept && instr.opcode == OP_RRC |=>
        carry_q == $past(acc_q[0]) && acc_q[7] == $past(carry_q))
        else $error("rotate right through carry wrong");
    data_pointer16_load_a: assert property (
        accept && instr.opcode == OP_LD_DATA_POINTER16 |->
        ##3 data_pointer16_q == {$past(instr.op1, 3), $past(instr.op2, 3)})
        else $error("data pointer load not 3 cycles");
    flash_write_a: assert property (
        accept && instr.opcode == OP_XW_DATA_POINTER16 && store_write_en |=>
        !flash_wr_q [*2] ##1 (flash_wr_q && xaddr_q == $past(data_pointer16_q, 3)))
        else $error("flash write missing after 3 cycles");
    mul_cycles_a: assert property (
        accept && instr.opcode == OP_MUL |=>
        !instr_ready_q [*3] ##1 done_q)
        else $error("multiply not 4 cycles");
    branch_skip_a: assert property (
        accept && instr.opcode == OP_JC |=>
        ##1 done_q == !$past(branch_taken, 2))
        else $error("branch timing wrong");
    code_read_a: assert property (
        accept && (dec.cls == CLS_CODE_DP || dec.cls == CLS_CODE_PC) |=>
        code_rd_q ##1 !code_rd_q)
        else $error("code read strobe not one cycle");
    branch_nt_a: assert property (
        accept && instr.opcode == OP_JC && !branch_taken |=> busy_then_done2)
        else $error("untaken branch not 2 cycles");
    branch_tk_a: assert property (
        accept && instr.opcode == OP_JC && branch_taken |=> busy_then_done3)
        else $error("taken branch not 3 cycles");
    spare_nop_a: assert property (
        accept && instr.opcode == OP_SPARE |=>
        done_q && instr_ready_q && $stable(acc_q) && $stable(carry_q) &&
        mem_space_q == MS_NONE)
        else $error("spare opcode not a no-operation");
    direct_sfr_a: assert property (
        accept && dec.mode == AM_DIR && instr.op1[SPACE_BIT] |=>
        mem_space_q == MS_SFR)
        else $error("direct high address not SFR");
    indirect_hi_a: assert property (
        accept && dec.mode == AM_IND && ri_value[SPACE_BIT] |=>
        mem_space_q == MS_RAM_HI)
        else $error("indirect high address not upper RAM");
endmodule // mit_core_timing

// ### testbench/mit_far_model.sv
// Purpose: Far side model of program flash and internal data RAM
// Assumes: Every read is answered at once from an address pattern
// Notes:   Keeps the last flash byte written so the bench can judge it
`timescale 1ns/1ps
module mit_far_model import mit_pkg::*; (
    input  wire logic        clk,
    input  wire mit_space_t  mem_space_q,
    input  wire logic [7:0]  mem_addr_q,
    input  wire logic        flash_wr_q,
    input  wire logic [15:0] xaddr_q,
    input  wire logic [7:0]  xwdata_q,
    output logic [7:0]       operand_data,
    output logic [15:0]      wr_addr = 16'hffff,
    output logic [7:0]       wr_data = 8'h00
);
    // SFRs and upper RAM share addresses, so each gets its own pattern
    assign operand_data = mem_addr_q ^
        ((mem_space_q == MS_SFR) ? 8'h3c : 8'h5a);
    // Flash takes the byte in the pulse cycle only; idle values above
    always @(posedge clk) begin
        if (flash_wr_q) begin
            wr_addr <= xaddr_q;
            wr_data <= xwdata_q;
        end
    end
endmodule // mit_far_model

// ### testbench/mit_core_timing_bench.sv
// Purpose: Self-checking bench for the instruction timing core
// Assumes: Standard opcode encodings; one instruction in flight
// Notes:   Cycle count is measured from acceptance to done
`timescale 1ns/1ps
module mit_core_timing_bench import mit_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, iv = 1'b0, bt = 1'b0, swe = 1'b0;
    logic ce = 1'b1;
    mit_instr_t  instr = '0;
    logic [7:0]  ri = 8'h90, opd, wd, acc_q, mem_addr_q, xw;
    logic [15:0] wa, data_pointer16_q, xa, ca;
    logic        rdy, done_q, carry_q, fw;
    logic [1:0]  len_q;
    logic [3:0]  cycles_q;
    mit_space_t  sp;
    int n, n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [15:0] tbl [] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422,
        16'h3811, 16'h9522, 16'h9612, 16'h5811, 16'h5612, 16'h5222,
        16'h5333, 16'h6222, 16'h4333, 16'he411, 16'hf411, 16'h2311,
        16'h0311, 16'hc411, 16'he811, 16'he522, 16'he612, 16'h7422,
        16'h8533, 16'h7533, 16'h8622, 16'hf612, 16'ha622, 16'h7622,
        16'h9033, 16'h9313, 16'h8313, 16'he213, 16'hf213, 16'he013,
        16'hf013, 16'hc022, 16'hd022, 16'hc811, 16'hc522, 16'h0411,
        16'ha311, 16'ha414, 16'h8418};
    always #2 clk = ~clk;
    mit_core_timing mit_core_timing_inst (.clk(clk), .rst_n(rst_n),
        .clk_en(ce), .instr(instr), .instr_valid(iv),
        .branch_taken(bt), .ri_value(ri), .pc_value(16'h0100),
        .operand_data(opd), .store_write_en(swe), .instr_ready_q(rdy),
        .done_q(done_q), .len_q(len_q), .cycles_q(cycles_q),
        .acc_q(acc_q), .carry_q(carry_q), .data_pointer16_q(data_pointer16_q),
        .mem_space_q(sp), .mem_addr_q(mem_addr_q), .flash_wr_q(fw),
        .xaddr_q(xa), .xwdata_q(xw), .code_rd_q(),
        .code_addr_q(ca));
    mit_far_model mit_far_model_inst (.clk(clk), .mem_space_q(sp),
        .mem_addr_q(mem_addr_q), .flash_wr_q(fw), .xaddr_q(xa),
        .xwdata_q(xw), .operand_data(opd), .wr_addr(wa), .wr_data(wd));
    task automatic end_of_test;
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One instruction; n counts cycles from acceptance to done
    task automatic run(input logic [7:0] op, a, b);
        @(posedge clk);
        iv <= 1'b1;
        instr <= {op, a, b};
        @(posedge clk);
        iv <= 1'b0;
        n = 1;
        #1;
        while (done_q !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic t_table;
        foreach (tbl[i]) begin
            run(tbl[i][15:8], 8'h01, 8'h02);
            chk(len_q, tbl[i][7:4]);
            chk(cycles_q, tbl[i][3:0]);
            chk(n[15:0], tbl[i][3:0]);
        end
    endtask
    // Carry set by an add, then pushed through both rotates
    task automatic t_rotate;
        run(8'h74, 8'h80, 8'h00);
        run(8'h24, 8'h80, 8'h00);
        run(8'h33, 8'h00, 8'h00);
        chk({acc_q, 7'h00, carry_q}, 16'h0100);
        run(8'h74, 8'h81, 8'h00);
        run(8'h13, 8'h00, 8'h00);
        chk({acc_q, 7'h00, carry_q}, 16'h4001);
        run(8'h33, 8'h00, 8'h00);
        chk({acc_q, 7'h00, carry_q}, 16'h8100);
        run(OP_SPARE, 8'h00, 8'h00);
        chk({acc_q, cycles_q, n[3:0]}, 16'h8111);
    endtask
    // Enable low freezes the core; the held request is taken after
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        iv <= 1'b1;
        instr <= {8'h04, 16'h0000};
        repeat (3) @(posedge clk);
        #1 chk({acc_q, 7'h00, done_q}, 16'h8100);
        @(posedge clk) ce <= 1'b1;
        @(posedge clk) iv <= 1'b0;
        #1 chk({acc_q, 7'h00, done_q}, 16'h8201);
    endtask
    task automatic t_branch;
        run(OP_JC, 8'h04, 8'h00);
        chk(n[15:0], 16'h0002);
        @(posedge clk) bt <= 1'b1;
        run(OP_JC, 8'h04, 8'h00);
        chk(n[15:0], 16'h0003);
        @(posedge clk) bt <= 1'b0;
    endtask
    // Direct above 0x7f reaches SFRs, indirect reaches upper RAM
    task automatic t_space;
        run(8'he5, 8'h90, 8'h00);
        chk({sp, mem_addr_q, acc_q[5:0]}, {MS_SFR, 14'h242c});
        run(8'he6, 8'h00, 8'h00);
        chk({sp, acc_q}, {MS_RAM_HI, 8'hca});
        run(8'he5, 8'h10, 8'h00);
        chk(sp, MS_RAM_LO);
    endtask
    task automatic t_flash;
        run(OP_LD_DATA_POINTER16, 8'h12, 8'h34);
        run(8'h74, 8'h5e, 8'h00);
        chk(data_pointer16_q, 16'h1234);
        @(posedge clk) swe <= 1'b1;
        run(OP_XW_DATA_POINTER16, 8'h00, 8'h00);
        @(posedge clk) #1 chk(wa, 16'h1234);
        run(8'h93, 8'h00, 8'h00);
        chk(ca, 16'h1292);
        @(posedge clk) swe <= 1'b0;
        run(8'h74, 8'h77, 8'h00);
        run(OP_XW_DATA_POINTER16, 8'h00, 8'h00);
        @(posedge clk) #1 chk(wd, 16'h005e);
    endtask
    // A hang is cut short well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_table();
        t_rotate();
        t_freeze();
        t_branch();
        t_space();
        t_flash();
        end_of_test();
    end
endmodule // mit_core_timing_bench
